//--- psp_pkg.sv
package psp_pkg;
   // clock rate and documented supply qualification time
   localparam int CLK_MHZ = 100;
   localparam int SUPPLY_QUAL_US = 20;
   localparam int SUPPLY_QUAL_CYC = SUPPLY_QUAL_US * CLK_MHZ;
   // defaults for times with no printed value, in clock cycles
   localparam int SUPPLY_HOLD_CYC_DEF = 200000;
   localparam int CURRENT_HOLD_CYC_DEF = 200000;
   localparam int OC_DELAY_CYC_DEF = 500;
   localparam int SC_DELAY_CYC_DEF = 200;
   localparam int CNT_W = 24;
   localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
   localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
   localparam int NUM_LOW = 4;      // low-side channels, last one is the brake
   localparam int BRAKE_IDX = 3;
   localparam logic [NUM_LOW-1:0] LOW_ZERO = 4'h0;

   typedef enum logic [3:0] {
      PSP_RUN = 4'h1,
      PSP_HOLD = 4'h2,
      PSP_LATCH = 4'h4,
      PSP_DEAD = 4'h8
   } psp_state_e;
endpackage

//--- psp_qual_if.sv
`timescale 1ns/1ps
// qualification counter controls between top and qualifier
interface psp_qual_if;
   logic run;
   logic [psp_pkg::CNT_W-1:0] limit;
   logic done;
   modport ctl (output run, output limit, input done);
   modport cnt (input run, input limit, output done);
endinterface

//--- psp_qual.sv
`timescale 1ns/1ps
// counts while run is high, restarts when run drops
module psp_qual (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // control
   psp_qual_if.cnt q
);
   import psp_pkg::*;
   logic [CNT_W-1:0] cnt_r;

   // done once the condition has held limit cycles in a row
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r <= CNT_ZERO;
      end else if (!q.run) begin
         cnt_r <= CNT_ZERO;
      end else if (cnt_r < q.limit) begin
         cnt_r <= cnt_r + CNT_ONE;
      end
   end
   assign q.done = q.run && (cnt_r >= q.limit - CNT_ONE);
endmodule // psp_qual

//--- psp_fault_protection.sv
`timescale 1ns/1ps
// Function
// - ignore supply dips shorter than 20 us
// - 20 us low supply: alarm, switch off
// - supply protection lasts whole hold period
// - resume needs command off and supply good
// - command on after hold: alarm ends, latched
// - one alarm pulse per protection episode
// - startup above 5 V: alarm 20 us later
// - below 5 V alarm released high
// - low-side alarms share one line
// - overcurrent after delay: alarm, soft off
// - overcurrent hold, then resume on command off
// - command off before delay: normal off
// - short circuit: limit now, trip after delay
// - short circuit uses current hold period
// - command off before short delay: no trip
// - protective off slow, command off normal
// - brake fault trips all low-side channels
module psp_fault_protection #(
   parameter int SUPPLY_HOLD_CYC = psp_pkg::SUPPLY_HOLD_CYC_DEF,
   parameter int CURRENT_HOLD_CYC = psp_pkg::CURRENT_HOLD_CYC_DEF,
   parameter int OC_DELAY_CYC = psp_pkg::OC_DELAY_CYC_DEF,
   parameter int SC_DELAY_CYC = psp_pkg::SC_DELAY_CYC_DEF
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // pwm command, active low, asynchronous
   input wire logic gate_cmd_n,
   // comparator flags, asynchronous
   input wire logic supply_below_thr,
   input wire logic supply_above_hyst,
   input wire logic supply_operating,
   input wire logic overcurrent_level,
   input wire logic short_circuit_level,
   // low-side group: faults of the other low-side channels, this channel is brake
   input wire logic is_brake,
   input wire logic [psp_pkg::NUM_LOW-1:0] low_fault_in,
   // switch control
   output logic gate_enable,
   output logic soft_off_sel,
   output logic current_limit,
   // alarm and status
   output logic fault_alarm_n,
   output logic fault_active,
   output logic supply_low_protection,
   output logic overcurrent_protection,
   output logic short_circuit_protection
);
   import psp_pkg::*;

   localparam logic [CNT_W-1:0] SUPPLY_QUAL_LIM = CNT_W'(SUPPLY_QUAL_CYC);
   localparam logic [CNT_W-1:0] SUPPLY_HOLD_LIM = CNT_W'(SUPPLY_HOLD_CYC);
   localparam logic [CNT_W-1:0] CURRENT_HOLD_LIM = CNT_W'(CURRENT_HOLD_CYC);
   localparam logic [CNT_W-1:0] OC_DELAY_LIM = CNT_W'(OC_DELAY_CYC);
   localparam logic [CNT_W-1:0] SC_DELAY_LIM = CNT_W'(SC_DELAY_CYC);
   localparam int NSYNC = 6 + NUM_LOW;

   // synchroniser stages
   logic [NSYNC-1:0] sync1_r;
   logic [NSYNC-1:0] sync2_r;
   logic [NSYNC-1:0] raw_in;
   logic cmd_on;
   logic uv_low;
   logic uv_good;
   logic vcc_ok;
   logic oc_hit;
   logic sc_hit;
   logic brake_s;
   logic [NUM_LOW-1:0] low_fault_s;
   // command synchroniser, resets to off so reset never turns the switch on
   logic gate_cmd_n_m;
   logic gate_cmd_n_s;

   // protection state
   psp_state_e state_r;
   psp_state_e state_nxt;
   logic [CNT_W-1:0] hold_r;
   logic [CNT_W-1:0] hold_lim_r;
   logic cause_uv_r;
   logic cause_oc_r;
   logic cause_sc_r;
   logic group_trip;
   logic uv_trip;
   logic oc_trip;
   logic sc_trip;
   logic any_trip;
   logic hold_done;
   logic release_ok;

   psp_qual_if uv_q ();
   psp_qual_if oc_q ();
   psp_qual_if sc_q ();

   assign raw_in = {low_fault_in, is_brake, short_circuit_level, overcurrent_level,
                    supply_operating, supply_above_hyst, supply_below_thr};

   // two flops per input; only sync2 is read by logic
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= raw_in;
         sync2_r <= sync1_r;
      end
   end

   // gate command taken low as on; input reads off until synchronised
   assign cmd_on = ~gate_cmd_n_s;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         gate_cmd_n_m <= 1'b1;
         gate_cmd_n_s <= 1'b1;
      end else begin
         gate_cmd_n_m <= gate_cmd_n;
         gate_cmd_n_s <= gate_cmd_n_m;
      end
   end

   assign uv_low = sync2_r[0];
   assign uv_good = sync2_r[1];
   assign vcc_ok = sync2_r[2];
   assign oc_hit = sync2_r[3];
   assign sc_hit = sync2_r[4];
   assign brake_s = sync2_r[5];
   assign low_fault_s = sync2_r[NSYNC-1:6];

   // qualification timers: a dip shorter than the limit restarts the count
   assign uv_q.run = vcc_ok && uv_low;
   assign uv_q.limit = SUPPLY_QUAL_LIM;
   assign oc_q.run = oc_hit && cmd_on && (state_r == PSP_RUN);
   assign oc_q.limit = OC_DELAY_LIM;
   assign sc_q.run = sc_hit && cmd_on && (state_r == PSP_RUN);
   assign sc_q.limit = SC_DELAY_LIM;

   psp_qual u_uv_qual (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .q(uv_q.cnt)
   );
   psp_qual u_oc_qual (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .q(oc_q.cnt)
   );
   psp_qual u_sc_qual (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .q(sc_q.cnt)
   );

   // brake channel is tripped only by brake faults; others also by any low-side fault
   always_comb begin
      group_trip = 1'b0;
      if (is_brake_sel(brake_s)) begin
         group_trip = low_fault_s[BRAKE_IDX];
      end else begin
         group_trip = |low_fault_s;
      end
   end

   function automatic logic is_brake_sel(input logic b);
      return b;
   endfunction

   assign uv_trip = uv_q.done;
   assign oc_trip = oc_q.done;
   assign sc_trip = sc_q.done;
   assign any_trip = uv_trip || oc_trip || sc_trip || group_trip;
   assign hold_done = (hold_r >= hold_lim_r);
   // release once hold ends with command off and supply good again
   assign release_ok = !cmd_on && (!cause_uv_r || uv_good);

   // episode sequencer
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         PSP_RUN: begin
            if (!vcc_ok) begin
               state_nxt = PSP_DEAD;
            end else if (any_trip) begin
               state_nxt = PSP_HOLD;
            end
         end
         PSP_HOLD: begin
            if (!vcc_ok) begin
               state_nxt = PSP_DEAD;
            end else if (hold_done) begin
               state_nxt = release_ok ? PSP_RUN : PSP_LATCH;
            end
         end
         PSP_LATCH: begin
            if (!vcc_ok) begin
               state_nxt = PSP_DEAD;
            end else if (release_ok) begin
               state_nxt = PSP_RUN;
            end
         end
         PSP_DEAD: begin
            if (vcc_ok) begin
               state_nxt = PSP_RUN;
            end
         end
         default: begin
            state_nxt = PSP_DEAD;
         end
      endcase
   end

   // state register; start dead until supply reaches operating level
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= PSP_DEAD;
      end else begin
         state_r <= state_nxt;
      end
   end

   // hold counter and its length, chosen by cause at trip time
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         hold_r <= CNT_ZERO;
         hold_lim_r <= SUPPLY_HOLD_LIM;
      end else if (state_r == PSP_RUN && state_nxt == PSP_HOLD) begin
         hold_r <= CNT_ONE;
         // current faults use the current hold period
         hold_lim_r <= uv_trip ? SUPPLY_HOLD_LIM : CURRENT_HOLD_LIM;
      end else if (state_r == PSP_HOLD && !hold_done) begin
         hold_r <= hold_r + CNT_ONE;
      end
   end

   // cause flags, cleared when the episode ends
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cause_uv_r <= 1'b0;
         cause_oc_r <= 1'b0;
         cause_sc_r <= 1'b0;
      end else if (state_nxt == PSP_RUN || state_nxt == PSP_DEAD) begin
         cause_uv_r <= 1'b0;
         cause_oc_r <= 1'b0;
         cause_sc_r <= 1'b0;
      end else if (state_r == PSP_RUN) begin
         cause_uv_r <= uv_trip;
         cause_oc_r <= oc_trip || (group_trip && !uv_trip && !sc_trip);
         cause_sc_r <= sc_trip;
      end else if (uv_trip) begin
         cause_uv_r <= 1'b1; // a later supply dip still needs good supply to release
      end
   end

   // outputs, all registered
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         gate_enable <= 1'b0;
         soft_off_sel <= 1'b0;
         current_limit <= 1'b0;
         fault_alarm_n <= 1'b1;
         fault_active <= 1'b0;
         supply_low_protection <= 1'b0;
         overcurrent_protection <= 1'b0;
         short_circuit_protection <= 1'b0;
      end else begin
         // command-driven off is normal speed, protective off selects slow path
         gate_enable <= (state_nxt == PSP_RUN) && cmd_on;
         soft_off_sel <= (state_nxt == PSP_HOLD) || (state_nxt == PSP_LATCH);
         current_limit <= sc_hit && (state_r == PSP_RUN);
         // one pulse per episode, released early if the supply collapses
         fault_alarm_n <= !(state_nxt == PSP_HOLD);
         fault_active <= (state_nxt == PSP_HOLD) || (state_nxt == PSP_LATCH);
         supply_low_protection <= cause_uv_r || (state_r == PSP_RUN && uv_trip);
         overcurrent_protection <= cause_oc_r || (state_r == PSP_RUN && oc_trip);
         short_circuit_protection <= cause_sc_r || (state_r == PSP_RUN && sc_trip);
      end
   end
endmodule // psp_fault_protection

//--- psp_pwm_model.sv
`timescale 1ns/1ps
// controller side of the optocoupler link
module psp_pwm_model (
   // clock
   input wire logic core_clk,
   // switch request from the bench
   input wire logic on_req,
   // command to the power stage
   output logic gate_cmd_n
);
   // starts high so the switch is requested off from time zero
   initial gate_cmd_n = 1'b1;
   // registered, active low command
   always @(posedge core_clk) begin
      gate_cmd_n <= !on_req;
   end
endmodule // psp_pwm_model

//--- psp_fault_protection_properties.sv
`timescale 1ns/1ps
module psp_fault_chk #(
   parameter int SUPPLY_HOLD_CYC = 1,
   parameter int CURRENT_HOLD_CYC = 1,
   parameter int OC_DELAY_CYC = 1
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // inputs
   input wire logic gate_cmd_n,
   input wire logic supply_below_thr,
   input wire logic supply_operating,
   input wire logic overcurrent_level,
   // outputs
   input wire logic gate_enable,
   input wire logic soft_off_sel,
   input wire logic fault_alarm_n,
   input wire logic fault_active,
   input wire logic overcurrent_protection
);
   localparam int HOLD_MAX = (SUPPLY_HOLD_CYC > CURRENT_HOLD_CYC) ? SUPPLY_HOLD_CYC : CURRENT_HOLD_CYC;
   int low_cnt_r;
   int oc_cnt_r;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // alarm length and steady overcurrent time, too long for a repetition
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         low_cnt_r <= 0;
         oc_cnt_r <= 0;
      end else begin
         low_cnt_r <= fault_alarm_n ? 0 : low_cnt_r + 1;
         oc_cnt_r <= (overcurrent_level && !gate_cmd_n && supply_operating && !supply_below_thr) ? oc_cnt_r + 1 : 0;
      end
   end
   alarm_len_a: assert property (fault_alarm_n || low_cnt_r < HOLD_MAX)
      else $error("alarm pulse too long");
   gate_off_a: assert property (fault_active |-> !gate_enable)
      else $error("switch on in protection");
   cmd_off_a: assert property (gate_cmd_n [*4] |=> !gate_enable)
      else $error("switch on with command off");
   soft_path_a: assert property (soft_off_sel == fault_active)
      else $error("turn-off path wrong");
   dead_alarm_a: assert property (!supply_operating [*4] |=> fault_alarm_n)
      else $error("alarm held without supply");
   alarm_cause_a: assert property ($fell(fault_alarm_n) |-> fault_active)
      else $error("alarm without protection");
   one_pulse_a: assert property (fault_active && $past(fault_active) && $past(fault_alarm_n) |-> fault_alarm_n)
      else $error("second alarm pulse");
   oc_trip_a: assert property (oc_cnt_r == OC_DELAY_CYC + 6 |-> fault_active)
      else $error("overcurrent not tripped");
   oc_hold_a: assert property ($rose(overcurrent_protection) |-> fault_active [*8])
      else $error("overcurrent hold cut short");
endmodule // psp_fault_chk
bind psp_fault_protection psp_fault_chk #(.SUPPLY_HOLD_CYC(SUPPLY_HOLD_CYC), .CURRENT_HOLD_CYC(CURRENT_HOLD_CYC),
   .OC_DELAY_CYC(OC_DELAY_CYC)) i_chk (.core_clk, .reset_n, .gate_cmd_n, .supply_below_thr, .supply_operating,
   .overcurrent_level, .gate_enable, .soft_off_sel, .fault_alarm_n, .fault_active, .overcurrent_protection);

//--- power_stage_fault_protection_bench.sv
`timescale 1ns/1ps
module power_stage_fault_protection_bench;
   import psp_pkg::*;
   localparam int SH = 50;
   localparam int CH = 50;
   localparam int QC = SUPPLY_QUAL_CYC;
   logic core_clk = 1'b0;
   logic reset_n, on_req, gate_cmd_n, supply_below_thr, supply_above_hyst, supply_operating;
   logic overcurrent_level, short_circuit_level, is_brake;
   logic [NUM_LOW-1:0] low_fault_in;
   logic gate_enable, soft_off_sel, current_limit, fault_alarm_n, fault_active;
   logic supply_low_protection, overcurrent_protection, short_circuit_protection;
   int n_mismatch = 0;
   int checks_done = 0;
   int t, len, d, r;
   always #5 core_clk = !core_clk;
   psp_pwm_model i_pwm (.core_clk, .on_req, .gate_cmd_n);
   psp_fault_protection #(.SUPPLY_HOLD_CYC(SH), .CURRENT_HOLD_CYC(CH), .OC_DELAY_CYC(20), .SC_DELAY_CYC(10))
      i_dut (.*);
   task automatic end_of_test();
      if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      checks_done++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   // cycles until the alarm falls, -1 if it never does
   task automatic wait_low(input int n, output int w);
      w = -1;
      for (int i = 1; i <= n && w < 0; i++) begin
         @(posedge core_clk);
         #1;
         if (fault_alarm_n === 1'b0) w = i;
      end
   endtask
   // remaining alarm cycles, capped so a stuck alarm cannot hang us
   task automatic low_len(output int n);
      n = 0;
      while (fault_alarm_n === 1'b0 && n < 5000) begin
         n++;
         @(posedge core_clk);
         #1;
      end
   endtask
   // hang guard, far beyond the expected run
   initial begin
      #400000;
      n_mismatch++;
      end_of_test();
   end
   initial begin
      void'($urandom(32'h20EE3B20));
      {reset_n, on_req, supply_below_thr, overcurrent_level, short_circuit_level, is_brake} = 6'h00;
      {supply_above_hyst, supply_operating} = 2'h3;
      low_fault_in = 4'h0;
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (10) @(posedge core_clk);
      on_req <= 1'b1;
      supply_below_thr <= 1'b1;
      repeat ($urandom_range(1900, 1)) @(posedge core_clk);
      supply_below_thr <= 1'b0;
      wait_low(2100, t);
      chk(t == -1 && gate_enable === 1'b1, "short dip tripped");
      supply_below_thr <= 1'b1;
      supply_above_hyst <= 1'b0;
      wait_low(2100, t);
      chk(t >= QC && t <= QC + 10 && soft_off_sel === 1'b1, "late supply trip");
      chk(supply_low_protection === 1'b1 && gate_enable === 1'b0, "supply cause flag");
      supply_below_thr <= 1'b0;
      supply_above_hyst <= 1'b1;
      low_len(len);
      chk(len == SH && gate_enable === 1'b0 && fault_active === 1'b1, "supply hold wrong");
      repeat (20) @(posedge core_clk);
      on_req <= 1'b0;
      #1;
      chk(fault_alarm_n === 1'b1 && gate_enable === 1'b0, "latched state wrong");
      repeat (6) @(posedge core_clk);
      #1;
      chk(fault_active === 1'b0, "no release");
      {supply_operating, supply_below_thr, supply_above_hyst} <= 3'h2;
      repeat (10) @(posedge core_clk);
      supply_operating <= 1'b1;
      wait_low(2100, t);
      low_len(len);
      chk(t >= QC && t <= QC + 10 && len == SH && fault_active === 1'b1, "startup alarm");
      @(posedge core_clk);
      {supply_below_thr, supply_above_hyst} <= 2'h1;
      repeat (6) @(posedge core_clk);
      #1;
      chk(fault_active === 1'b0, "no release after startup");
      supply_below_thr <= 1'b1;
      wait_low(2100, t);
      supply_operating <= 1'b0;
      repeat (5) @(posedge core_clk);
      #1;
      chk(fault_alarm_n === 1'b1, "alarm held below operating");
      {supply_operating, supply_below_thr, supply_above_hyst} <= 3'h5;
      repeat (10) @(posedge core_clk);
      // overcurrent then short circuit: aborted, then tripped
      for (int k = 0; k < 2; k++) begin
         d = k ? 10 : 20;
         r = $urandom_range(d - 5, 1);
         on_req <= 1'b1;
         repeat (8) @(posedge core_clk);
         {overcurrent_level, short_circuit_level} <= k ? 2'h1 : 2'h2;
         repeat (r) @(posedge core_clk);
         on_req <= 1'b0;
         wait_low(d + 10, t);
         chk(t == -1 && soft_off_sel === 1'b0, "tripped after command off");
         on_req <= 1'b1;
         repeat (4) @(posedge core_clk);
         #1;
         chk(k == 0 || current_limit === 1'b1, "no current limit");
         wait_low(d + 10, t);
         chk(t + 4 >= d && t + 4 <= d + 6 && soft_off_sel === 1'b1, "current trip time");
         chk((k ? short_circuit_protection : overcurrent_protection) === 1'b1, "cause flag");
         {on_req, overcurrent_level, short_circuit_level} <= 3'h0;
         repeat (20) @(posedge core_clk);
         #1;
         chk(gate_enable === 1'b0 && fault_active === 1'b1, "hold released early");
         low_len(len);
         chk(len == CH - 20, "current hold length");
         repeat (5) @(posedge core_clk);
         #1;
         chk(fault_active === 1'b0, "no current release");
      end
      low_fault_in <= 4'h8;
      repeat (6) @(posedge core_clk);
      #1;
      chk(fault_active === 1'b1, "brake fault ignored");
      low_fault_in <= 4'h0;
      repeat (CH + 10) @(posedge core_clk);
      {is_brake, low_fault_in} <= 5'h11;
      repeat (6) @(posedge core_clk);
      #1;
      chk(fault_active === 1'b0, "brake tripped by low side");
      end_of_test();
   end
endmodule // power_stage_fault_protection_bench
